// File: include/wakeup_regs.svh
// constants for the low-power wake-up qualifier
`ifndef WAKEUP_REGS_SVH
`define WAKEUP_REGS_SVH
`define N_EXT_PIN    8
`define N_TIMER      10
`define N_CAPTURE    14
`define N_SERIAL     3
`define N_CONVERTER  4
`define EXIT_CYCLES  4'h2
`define MASK_RST     1'b0
`endif

// File: include/wakeup_pkg.sv
// types for the low-power wake-up qualifier
package wakeup_pkg;
	typedef enum logic [1:0] {
		mode_idle,
		mode_sleep,
		mode_stop
	} lp_mode_e;

	typedef struct packed {
		logic [7:0]  ext_pin_irq;
		logic        rtc_irq;
		logic [9:0]  timer_irq;
		logic [13:0] capture_irq;
		logic [2:0]  serial_rx_irq;
		logic [2:0]  serial_tx_irq;
		logic [2:0]  serial_bus_irq;
		logic [3:0]  converter_irq;
	} irq_src_s;

	typedef struct packed {
		logic watchdog_nmi;
		logic nmi_pin;
	} nmi_src_s;

	typedef enum logic [1:0] {
		cause_none,
		cause_irq,
		cause_nmi
	} cause_e;
endpackage

// File: core/wakeup_source_filter.sv
// mode qualification of release sources
module wakeup_source_filter
	import wakeup_pkg::*;
(
	input  wire wakeup_pkg::lp_mode_e mode,
	input  wire wakeup_pkg::irq_src_s irq,
	input  wire logic [45:0]          irq_enable,
	input  wire wakeup_pkg::nmi_src_s nmi,
	output logic                      irq_wake,
	output logic                      nmi_wake
);
	irq_src_s q;

	// ------------------------------------------------
	// per-source mode qualification
	// ------------------------------------------------
	always_comb begin
		q = irq & irq_src_s'(irq_enable);
		if (mode == mode_stop) begin
			q.rtc_irq = 1'b0;
		end
		if (mode != mode_idle) begin
			q.timer_irq      = '0;
			q.capture_irq    = '0;
			q.serial_rx_irq  = '0;
			q.serial_tx_irq  = '0;
			q.serial_bus_irq = '0;
			q.converter_irq  = '0;
		end
		irq_wake = |q;
		nmi_wake = nmi.nmi_pin | (nmi.watchdog_nmi && mode == mode_idle);
	end
endmodule

// File: core/low_power_wakeup_qualifier.sv
// low-power mode entry, wake-up and exit sequencing
`include "wakeup_regs.svh"
module low_power_wakeup_qualifier (
	input  wire logic                     clk_sys,
	input  wire logic                     nrst,
	input  wire logic                     enter_req,
	input  wire wakeup_pkg::lp_mode_e     mode_sel,
	input  wire wakeup_pkg::irq_src_s     irq,
	input  wire logic [45:0]              irq_enable,
	input  wire wakeup_pkg::nmi_src_s     nmi,
	input  wire logic                     mask_wr,
	input  wire logic                     mask_wdata,
	input  wire logic                     privileged,
	input  wire logic                     fault,
	input  wire logic                     handling_ack,
	output logic                          low_power,
	output wakeup_pkg::lp_mode_e          mode,
	output logic                          wake_req,
	output logic                          handle_irq,
	output logic                          handle_nmi,
	output logic                          hard_fault,
	output logic                          global_irq_mask
);
	import wakeup_pkg::*;

	typedef enum logic [1:0] {
		st_normal,
		st_low_power,
		st_exit,
		st_handle
	} seq_e;

	seq_e        state;
	cause_e      cause;
	logic [3:0]  exit_cnt;
	logic        irq_wake;
	logic        nmi_wake;
	logic        irq_ok;

	// ------------------------------------------------
	// source qualification
	// ------------------------------------------------
	wakeup_source_filter u_filter (
		.mode       (mode),
		.irq        (irq),
		.irq_enable (irq_enable),
		.nmi        (nmi),
		.irq_wake   (irq_wake),
		.nmi_wake   (nmi_wake)
	);

	assign irq_ok = irq_wake & ~global_irq_mask;

	// ------------------------------------------------
	// global interrupt mask
	// ------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			global_irq_mask <= `MASK_RST;
		end else if (mask_wr && privileged) begin
			global_irq_mask <= mask_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			hard_fault <= 1'b0;
		end else begin
			hard_fault <= fault & global_irq_mask;
		end
	end

	// ------------------------------------------------
	// mode sequencer
	// ------------------------------------------------
	// reset returns to normal
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state    <= st_normal;
			mode     <= mode_idle;
			cause    <= cause_none;
			exit_cnt <= 4'h0;
		end else begin
			case (state)
				st_normal: begin
					if (enter_req) begin
						state <= st_low_power;
						mode  <= mode_sel;
					end
				end
				st_low_power: begin
					if (nmi_wake) begin
						state    <= st_exit;
						cause    <= cause_nmi;
						exit_cnt <= `EXIT_CYCLES;
					end else if (irq_ok) begin
						state    <= st_exit;
						cause    <= cause_irq;
						exit_cnt <= `EXIT_CYCLES;
					end
				end
				st_exit: begin
					if (exit_cnt == 4'h1) begin
						state <= st_handle;
					end
					exit_cnt <= exit_cnt - 4'h1;
				end
				st_handle: begin
					if (handling_ack) begin
						state <= st_normal;
						cause <= cause_none;
					end
				end
				default: begin
					state <= st_normal;
				end
			endcase
		end
	end

	// ------------------------------------------------
	// registered outputs
	// ------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			low_power <= 1'b0;
			wake_req  <= 1'b0;
		end else begin
			low_power <= (state == st_low_power && !nmi_wake && !irq_ok)
				|| (state == st_normal && enter_req);
			wake_req  <= state == st_low_power && (nmi_wake || irq_ok);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			handle_irq <= 1'b0;
			handle_nmi <= 1'b0;
		end else begin
			handle_irq <= state == st_exit && exit_cnt == 4'h1
				&& cause == cause_irq;
			handle_nmi <= state == st_exit && exit_cnt == 4'h1
				&& cause == cause_nmi;
		end
	end
endmodule

// File: verification/wakeup_monitor.sv
// checker for the low-power wake-up qualifier
module wakeup_monitor (
	input wire logic clk_sys, nrst, low_power, wake_req,
	input wire logic handle_irq, handle_nmi, fault,
	input wire logic hard_fault, global_irq_mask,
	input wire logic [45:0] irq_enable,
	input wire wakeup_pkg::irq_src_s irq,
	input wire wakeup_pkg::nmi_src_s nmi,
	input wire wakeup_pkg::lp_mode_e mode
);
	timeunit 1ns;
	timeprecision 1ns;
	import wakeup_pkg::*;
	logic pin, quiet;
	assign pin = |(irq.ext_pin_irq & irq_enable[45:38]);
	assign quiet = low_power && !pin && !nmi.nmi_pin;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	property p_exit; wake_req |-> $past(low_power) && !low_power; endproperty
	property p_hand; wake_req |-> ##2 (handle_irq || handle_nmi); endproperty
	property p_nmi; low_power && nmi.nmi_pin |=> wake_req; endproperty
	property p_pin; low_power && pin && !global_irq_mask |=> wake_req;
	endproperty
	property p_sleep;
		quiet && mode == mode_sleep && !(irq.rtc_irq && irq_enable[37])
		|=> !wake_req;
	endproperty
	property p_stop; quiet && mode == mode_stop |=> !wake_req; endproperty
	property p_mask;
		low_power && global_irq_mask && !nmi.nmi_pin
		&& !(nmi.watchdog_nmi && mode == mode_idle) |=> !wake_req;
	endproperty
	property p_hard; fault && global_irq_mask |=> hard_fault; endproperty
	a_exit: assert property (p_exit) else $error("no exit");
	a_hand: assert property (p_hand) else $error("no handling");
	a_nmi: assert property (p_nmi) else $error("nmi ignored");
	a_pin: assert property (p_pin) else $error("pin ignored");
	a_sleep: assert property (p_sleep) else $error("sleep woke");
	a_stop: assert property (p_stop) else $error("stop woke");
	a_mask: assert property (p_mask) else $error("mask leak");
	a_hard: assert property (p_hard) else $error("no hard");
	cover property (wake_req);
	cover property (hard_fault);
	cover property (low_power && mode == mode_stop);
endmodule
bind low_power_wakeup_qualifier wakeup_monitor wakeup_monitor_inst (.*);

// File: verification/tb.sv
// testbench for the low-power wake-up qualifier
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import wakeup_pkg::*;
	logic clk_sys = 0, nrst = 0, enter_req = 0, mask_wr = 0, fault = 0;
	logic mask_wdata = 0, privileged = 0, handling_ack = 0;
	logic low_power, wake_req, handle_irq, handle_nmi, hard_fault;
	logic global_irq_mask;
	logic [45:0] irq_enable = '1;
	lp_mode_e mode_sel = mode_idle, mode;
	irq_src_s irq = '0;
	nmi_src_s nmi = '0;
	int bad_count = 0, check_count = 0;
	localparam logic [4:0] ok [3] = '{5'h1f, 5'h19, 5'h11};
	always #10 clk_sys = ~clk_sys;
	low_power_wakeup_qualifier low_power_wakeup_qualifier_inst (.*);
	task automatic chk(input logic [7:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %h %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("checks %0d bad %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task t(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic run(input int m, s, input logic w);
		logic [7:0] n, h, nh;
		n = 0;
		h = 0;
		nh = 0;
		mode_sel = lp_mode_e'(m);
		enter_req = 1;
		t(1);
		enter_req = 0;
		chk({low_power, mode}, {1'b1, mode_sel});
		{irq.ext_pin_irq[0], irq.rtc_irq, irq.timer_irq[0], nmi} = 5'h10 >> s;
		repeat (4) begin
			t(1);
			n += wake_req;
			h += handle_irq | handle_nmi;
			nh += handle_nmi;
		end
		chk(n, w);
		chk(h, w);
		chk(nh, w && s > 2);
		irq = '0;
		nmi = {1'b0, !w};
		t(4);
		nmi = '0;
		handling_ack = 1;
		t(1);
		handling_ack = 0;
		t(1);
	endtask
	task automatic wr_mask(input logic p, d);
		privileged = p;
		mask_wdata = d;
		mask_wr = 1;
		t(1);
		mask_wr = 0;
		t(1);
	endtask
	task automatic t_mask;
		wr_mask(0, 1);
		chk(global_irq_mask, 0);
		wr_mask(1, 1);
		run(1, 0, 0);
		run(1, 4, 1);
		fault = 1;
		t(1);
		chk(hard_fault, 1);
		fault = 0;
		wr_mask(1, 0);
		fault = 1;
		t(1);
		chk(hard_fault, 0);
		fault = 0;
	endtask
	task automatic t_reset;
		wr_mask(1, 1);
		mode_sel = mode_stop;
		enter_req = 1;
		t(1);
		enter_req = 0;
		nrst = 0;
		t(2);
		nrst = 1;
		chk({low_power, global_irq_mask, mode}, 0);
	endtask
	initial begin
		t(20);
		nrst = 1;
		chk({low_power, wake_req, global_irq_mask}, 0);
		for (int m = 0; m < 3; m++)
			for (int s = 0; s < 5; s++)
				run(m, s, ok[m][4 - s]);
		irq_enable = '0;
		run(2, 0, 0);
		irq_enable = '1;
		t_mask;
		t_reset;
		print_verdict;
	end
	initial begin
		#50us;
		bad_count++;
		print_verdict;
	end
endmodule
